// ===== adc_channel_ctrl.sv
// Converter channel control: input mux, interrupt flag, result format
module adc_channel_ctrl
  import adc_chan_pkg::*;
#(
  parameter int RESULT_W = 12
) (
  // APB slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [adc_chan_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Converter core
  input  wire logic                      conv_done,
  input  wire logic [RESULT_W-1:0]       conv_result_word,
  input  wire logic                      cmp_below,
  input  wire logic                      cmp_above,
  output logic      [4:0]                pos_source,
  output logic      [4:0]                neg_source,
  output logic                           signed_conv,
  // Interrupt controller
  input  wire logic                      vector_ack,
  output logic      [1:0]                irq_priority_level,
  output logic                           irq_request,
  output logic                           irq
);
  import adc_chan_pkg::*;

  // Formatting slices are fixed to a 12-bit result word
  if (RESULT_W != 12) begin : g_width_check
    $error("RESULT_W must be 12");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] input_select;
  logic [7:0] irq_control;
  logic [7:0] irq_mask;
  logic       flag;
  logic [7:0] result_low;
  logic [7:0] result_high;
  logic [7:0] high_hold;
  logic [7:0] next_low;
  logic [7:0] next_high;

  logic        wr_en;
  logic        rd_en;
  logic [3:0]  reg_idx;
  logic        mapped;

  assign reg_idx = paddr[ADDR_W-1:2];
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign mapped  = reg_idx <= IDX_IRQ_MASK && paddr[1:0] == 2'h0;
  assign pslverr = psel && penable && !mapped;

  function automatic logic hit(input logic [3:0] idx);
    hit = wr_en && reg_idx == idx && paddr[1:0] == 2'h0;
  endfunction

  channel_input_kind_t kind;
  irq_condition_t      cond;
  result_format_t      fmt;
  assign kind        = channel_input_kind_t'(control[KIND_LSB +: 2]);
  assign fmt         = result_format_t'(control[FMT_LSB +: 2]);
  assign signed_conv = control[SIGNED_BIT];
  assign cond        = irq_condition_t'(irq_control[COND_LSB +: 2]);

  // ----------------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= RESET_BYTE;
    end else if (hit(IDX_CONTROL)) begin
      // Differential kinds are refused unless signed conversion is set
      if (pwdata[1] && !pwdata[SIGNED_BIT]) begin
        control <= {pwdata[7:2], 2'h0} & CTRL_MASK;
      end else begin
        control <= pwdata[7:0] & CTRL_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select <= RESET_BYTE;
    end else if (hit(IDX_INPUT_SELECT)) begin
      // Reserved bit 7 kept zero regardless of software
      input_select <= pwdata[7:0] & INPUT_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control <= RESET_BYTE;
    end else if (hit(IDX_IRQ_CONTROL)) begin
      irq_control <= pwdata[7:0] & IRQC_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= RESET_BYTE;
    end else if (hit(IDX_IRQ_MASK)) begin
      irq_mask <= pwdata[7:0] & 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Input multiplexer decode
  // ----------------------------------------------------------------------
  logic [3:0] pos_code;
  logic [2:0] neg_code;
  assign pos_code = input_select[POS_SEL_LSB +: 4];
  assign neg_code = input_select[NEG_SEL_LSB +: 3];

  always_comb begin
    pos_source = SRC_NONE;
    unique case (kind)
      KIND_INTERNAL: begin
        unique case (pos_code)
          4'h0:    pos_source = SRC_TEMP;
          4'h1:    pos_source = SRC_BANDGAP;
          4'h2:    pos_source = scaled_supply_select;
          default: pos_source = SRC_NONE;
        endcase
      end
      default: pos_source = {1'b0, pos_code};
    endcase
  end

  always_comb begin
    neg_source = SRC_NONE;
    unique case (kind)
      KIND_DIFF: begin
        if (!neg_code[2]) begin
          neg_source = {2'h0, neg_code};
        end else if (neg_code == NEG_PAD_GND) begin
          neg_source = SRC_PAD_GND;
        end else if (neg_code == NEG_INT_GND) begin
          neg_source = internal_ground_select;
        end
      end
      differential_gain_input: begin
        if (!neg_code[2]) begin
          neg_source = GAIN_PIN_BASE + {2'h0, neg_code};
        end else if (neg_code == NEG_GAIN_INTERNAL_GROUND_SELECT) begin
          neg_source = internal_ground_select;
        end else if (neg_code == NEG_GAIN_PADGND) begin
          neg_source = SRC_PAD_GND;
        end
      end
      default: neg_source = SRC_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------------
  logic set_flag;
  always_comb begin
    set_flag = 1'b0;
    if (conv_done) begin
      unique case (cond)
        COND_COMPLETE: set_flag = 1'b1;
        COND_BELOW:    set_flag = cmp_below;
        COND_ABOVE:    set_flag = cmp_above;
        default:       set_flag = 1'b0;
      endcase
    end
  end

  // Set beats a same-cycle clear so no completion is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set_flag) begin
      flag <= 1'b1;
    end else if (vector_ack) begin
      flag <= 1'b0;
    end else if (hit(IDX_IRQ_FLAG) && pwdata[FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  assign irq_priority_level = irq_control[LEVEL_LSB +: 2];
  assign irq_request = flag && irq_priority_level != 2'h0;
  assign irq         = flag && irq_mask[FLAG_BIT];

  // ----------------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------------
  logic diff_kind;
  assign diff_kind = kind[1];

  always_comb begin
    next_low  = RESET_BYTE;
    next_high = RESET_BYTE;
    unique case (fmt)
      FMT_12_LEFT: begin
        next_high = conv_result_word[11:4];
        next_low  = {conv_result_word[3:0], 4'h0};
      end
      FMT_8: begin
        next_low  = conv_result_word[7:0];
        // Two's complement extension from bit 7 when signed, zero fill otherwise
        next_high = {8{signed_conv && conv_result_word[7]}};
      end
      default: begin
        next_low  = conv_result_word[7:0];
        next_high = {{4{diff_kind && conv_result_word[11]}},
                     conv_result_word[11:8]};
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_low  <= RESET_BYTE;
      result_high <= RESET_BYTE;
    end else if (conv_done) begin
      result_low  <= next_low;
      result_high <= next_high;
    end
  end

  // Low read freezes the matching high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_hold <= RESET_BYTE;
    end else if (rd_en && reg_idx == IDX_RESULT_LOW) begin
      high_hold <= result_high;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && !mapped) begin
      // Refused reads return zero, unaligned ones included
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (reg_idx)
        IDX_CONTROL:      prdata <= {24'h0, control};
        IDX_INPUT_SELECT: prdata <= {24'h0, input_select};
        IDX_IRQ_CONTROL:  prdata <= {24'h0, irq_control};
        IDX_IRQ_FLAG:     prdata <= {31'h0, flag};
        IDX_RESULT_LOW:   prdata <= {24'h0, result_low};
        IDX_RESULT_HIGH:  prdata <= {24'h0, high_hold};
        IDX_IRQ_MASK:     prdata <= {24'h0, irq_mask};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== adc_chan_pkg.sv
// Shared constants and types for the converter channel control block
package adc_chan_pkg;

  // ----------------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_CONTROL      = 4'h0;
  localparam logic [3:0] IDX_INPUT_SELECT = 4'h1;
  localparam logic [3:0] IDX_IRQ_CONTROL  = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAG     = 4'h3;
  localparam logic [3:0] IDX_RESULT_LOW   = 4'h4;
  localparam logic [3:0] IDX_RESULT_HIGH  = 4'h5;
  localparam logic [3:0] IDX_IRQ_MASK     = 4'h6;
  localparam int         ADDR_W           = 6;

  // ----------------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------------
  localparam int         POS_SEL_LSB = 3;
  localparam int         NEG_SEL_LSB = 0;
  localparam int         COND_LSB    = 2;
  localparam int         LEVEL_LSB   = 0;
  localparam int         KIND_LSB    = 0;
  localparam int         FMT_LSB     = 2;
  localparam int         SIGNED_BIT  = 4;
  localparam int         FLAG_BIT    = 0;
  localparam logic [7:0] INPUT_MASK  = 8'h7F;
  localparam logic [7:0] IRQC_MASK   = 8'h0F;
  localparam logic [7:0] CTRL_MASK   = 8'h1F;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_INTERNAL     = 2'h0,
    single_ended_input = 2'h1,
    KIND_DIFF         = 2'h2,
    differential_gain_input = 2'h3
  } channel_input_kind_t;

  typedef enum logic [1:0] {
    COND_COMPLETE = 2'h0,
    COND_BELOW    = 2'h1,
    COND_RSVD     = 2'h2,
    COND_ABOVE    = 2'h3
  } irq_condition_t;

  typedef enum logic [1:0] {
    FMT_12_RIGHT = 2'h0,
    FMT_8        = 2'h1,
    FMT_12_LEFT  = 2'h2
  } result_format_t;

  // Analog source codes driven to the core mux, then negative select field codes and the gain pin base
  localparam logic [4:0] SRC_TEMP        = 5'h10;
  localparam logic [4:0] SRC_BANDGAP     = 5'h11;
  localparam logic [4:0] scaled_supply_select = 5'h12;
  localparam logic [4:0] SRC_PAD_GND     = 5'h14;
  localparam logic [4:0] internal_ground_select = 5'h15;
  localparam logic [4:0] SRC_NONE        = 5'h1F;
  localparam logic [2:0] NEG_PAD_GND     = 3'h5;
  localparam logic [2:0] NEG_INT_GND     = 3'h7;
  localparam logic [2:0] NEG_GAIN_INTERNAL_GROUND_SELECT = 3'h4;
  localparam logic [2:0] NEG_GAIN_PADGND = 3'h7;
  localparam logic [4:0] GAIN_PIN_BASE   = 5'h04;

endpackage

// ===== adc_chan_sva.sv
// Port checker for the converter channel control block
module adc_chan_sva
  import adc_chan_pkg::*;
(
  // Bus, converter and interrupt side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [5:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_done,
  input wire logic [4:0]  pos_source,
  input wire logic [4:0]  neg_source,
  input wire logic        signed_conv,
  input wire logic        vector_ack,
  input wire logic [1:0]  irq_priority_level,
  input wire logic        irq_request,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_flag_clr;
    s_access ##0 pwrite && pstrb[0] && paddr == 6'h0C && pwdata[0];
  endsequence
  a_zero_wait: assert property (s_access |-> pready)
    else $error("access not answered at once");
  a_err_map: assert property (s_access |->
    pslverr == (paddr[1:0] != 2'h0 || paddr[5:2] > 4'h6))
    else $error("slave error does not match address");
  a_err_data: assert property (s_access ##0 pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read returned data");
  a_req_enable: assert property (irq_request |-> irq_priority_level != 0)
    else $error("request with interrupt disabled");
  a_req_rise: assert property ($rose(irq_request) |->
    $past(conv_done) || $past(irq_priority_level) == 2'h0)
    else $error("request rose without cause");
  a_ack_clear: assert property (vector_ack && !conv_done |=> !irq_request)
    else $error("flag survived vector ack");
  a_write_clear: assert property (s_flag_clr ##0 !conv_done |=> !irq)
    else $error("flag survived write of one");
  a_pos_legal: assert property (pos_source < 5'h13 || pos_source == 5'h1F)
    else $error("illegal positive source");
  a_neg_legal: assert property (neg_source < 5'h08 ||
    neg_source inside {5'h14, 5'h15, 5'h1F})
    else $error("illegal negative source");
  a_diff_signed: assert property (neg_source != 5'h1F |-> signed_conv)
    else $error("negative input used while unsigned");
endmodule

bind adc_channel_ctrl adc_chan_sva adc_chan_sva_inst (.*);

// ===== conv_core_model.sv
// Behavioural converter core feeding results and compare levels
module conv_core_model (
  // Commands from the bench
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [11:0] value,
  input  wire logic        below,
  input  wire logic        above,
  // Toward the channel block
  output logic             conv_done,
  output logic [11:0]      conv_result_word,
  output logic             cmp_below,
  output logic             cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines toggle outside a completion so stale data never passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done        <= 1'b0;
      conv_result_word <= 12'h000;
      cmp_below        <= 1'b0;
      cmp_above        <= 1'b0;
    end else begin
      conv_done        <= start;
      conv_result_word <= start ? value : ~conv_result_word;
      cmp_below        <= start ? below : ~cmp_below;
      cmp_above        <= start ? above : ~cmp_above;
    end
  end
endmodule

// ===== adc_channel_ctrl_test.sv
// Self-checking bench for the converter channel control block
module adc_channel_ctrl_test;
  import adc_chan_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, start = 1'b0, below = 1'b0, above = 1'b0;
  logic        vector_ack = 1'b0, pready, pslverr, err, conv_done;
  logic        cmp_below, cmp_above, signed_conv, irq_request, irq;
  logic [5:0]  paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [11:0] value = 12'h000, conv_result_word;
  logic [4:0]  pos_source, neg_source;
  logic [1:0]  irq_priority_level;
  int          failures = 0, checks = 0;
  // ctrl, input select, positive source, negative source
  logic [31:0] mux_tab [15] = '{32'h0000101F, 32'h000D111F, 32'h0010121F,
    32'h00181F1F, 32'h017D0F1F, 32'h121D0314, 32'h12070015, 32'h1204001F,
    32'h12010001, 32'h13000004, 32'h13030007, 32'h13040015, 32'h13070014,
    32'h1305001F, 32'h0208111F};
  // ctrl, result, low byte, high byte
  logic [35:0] fmt_tab [7] = '{36'h01ABCBC0A, 36'h12ABCBCFA, 36'h125BCBC05,
    36'h1538585FF, 36'h0538585_00, 36'h09ABCC0AB, 36'h0DABCBC0A};
  // condition, below, above, flag expected
  logic [4:0]  irq_tab [6] = '{5'h01, 5'h0D, 5'h16, 5'h0A, 5'h1B, 5'h1C};

  adc_channel_ctrl adc_channel_ctrl_inst (.*);
  conv_core_model conv_core_model_inst (.*);

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [5:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    apb(1'b1, a, 32'(d));
  endtask

  task automatic rdc(string nm, logic [5:0] a, logic [7:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, 32'(e), rd);
  endtask

  task automatic conv(logic [11:0] v, logic b, logic a);
    @(posedge pclk);
    start <= 1'b1;
    value <= v;
    below <= b;
    above <= a;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic give_verdict;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    give_verdict;
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 7; i++) rdc("reset value", 6'(i * 4), 8'h00);
    apb(1'b0, 6'h1C, 32'h0);
    cmp("unmapped error", 32'h1, 32'(err));
    cmp("unmapped data", 32'h0, rd);
    foreach (mux_tab[i]) begin
      wr(6'h00, mux_tab[i][31:24]);
      wr(6'h04, mux_tab[i][23:16]);
      rdc("input select", 6'h04, mux_tab[i][23:16]);
      @(negedge pclk);
      cmp("pos source", 32'(mux_tab[i][15:8]), 32'(pos_source));
      cmp("neg source", 32'(mux_tab[i][7:0]), 32'(neg_source));
    end
    foreach (fmt_tab[i]) begin
      wr(6'h00, fmt_tab[i][35:28]);
      conv(fmt_tab[i][27:16], 1'b0, 1'b0);
      rdc("result low", 6'h10, fmt_tab[i][15:8]);
      rdc("result high", 6'h14, fmt_tab[i][7:0]);
    end
    rdc("result low", 6'h10, 8'hBC);
    conv(12'h123, 1'b0, 1'b0);
    rdc("held high", 6'h14, 8'h0A);
    rdc("result low", 6'h10, 8'h23);
    rdc("result high", 6'h14, 8'h01);
    wr(6'h18, 8'h01);
    foreach (irq_tab[i]) begin
      wr(6'h08, {4'h0, irq_tab[i][4:3], 2'h2});
      conv(12'h055, irq_tab[i][2], irq_tab[i][1]);
      cmp("irq request", 32'(irq_tab[i][0]), 32'(irq_request));
      cmp("irq", 32'(irq_tab[i][0]), 32'(irq));
      cmp("level", 32'h2, 32'(irq_priority_level));
      wr(6'h0C, 8'h00);
      rdc("flag kept", 6'h0C, 8'(irq_tab[i][0]));
      wr(6'h0C, 8'h01);
      rdc("flag cleared", 6'h0C, 8'h00);
    end
    wr(6'h08, 8'h01);
    conv(12'h000, 1'b0, 1'b0);
    cmp("request before ack", 32'h1, 32'(irq_request));
    @(posedge pclk);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    rdc("flag after ack", 6'h0C, 8'h00);
    wr(6'h18, 8'h00);
    wr(6'h08, 8'h00);
    conv(12'h000, 1'b0, 1'b0);
    cmp("masked irq", 32'h0, 32'(irq));
    cmp("disabled request", 32'h0, 32'(irq_request));
    wr(6'h08, 8'h03);
    @(negedge pclk);
    cmp("late request", 32'h1, 32'(irq_request));
    give_verdict;
  end
endmodule
